// file: rtl/dpv_pkg.sv
// Purpose: constants and types for the deserializer parallel video output
// Assumes: system clock 40 MHz; recovered pixel clock runs free
// Notes: straps sampled on the colour pins after power-up
// Notes on behaviour
// - colour buses are 8 bits, bit 7 msb
// - power-down: colour pins follow output-state select
// - power-down: control outputs follow output-state select
// - colour pins are inputs during power-up
// - filter on: control pulses of 3 clocks pass
// - filter off: no minimum control pulse width
// - locked output high only when outputs active
// - straps sampled once at power-up, default low
// - link mode: 00 plain, 01 filtered, 10/11 compat
// - clock edge select picks the launch edge
package dpv_pkg;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dpv_rgb_t;

  typedef struct packed {
    dpv_rgb_t rgb;
    logic frame_sync;
    logic line_sync;
    logic pixel_valid;
  } dpv_pixel_t;

  localparam logic [1:0] MODE_NATIVE = 2'h0;
  localparam logic [1:0] MODE_NATIVE_FILT = 2'h1;
  localparam logic [1:0] MODE_COMPAT_A = 2'h2;
  localparam logic [1:0] MODE_COMPAT_B = 2'h3;

  localparam int FILTER_MIN_CLOCKS = 3;
  localparam int PIPE_DEPTH = FILTER_MIN_CLOCKS + 1;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int STRAP_TIME_NS = 1000;
  localparam int STRAP_CYCLES =
    (STRAP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRAP_CNT_W = $clog2(STRAP_CYCLES + 1);
  localparam logic [STRAP_CNT_W-1:0] STRAP_CNT_LOAD =
    STRAP_CNT_W'(STRAP_CYCLES - 1);

  // link mode strap sits on blue bits 7:6
  localparam int STRAP_MODE_LSB = 6;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STRAP = 4'h8;

  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_EDGE_BIT = 3;
  localparam logic CTRL_OVR_RESET = 1'h0;
  localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
  localparam logic CTRL_EDGE_RESET = 1'h1;

  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_ACTIVE_BIT = 3;
  localparam int STAT_STRAP_LSB = 4;
  localparam int STAT_MODE_LSB = 6;
  localparam int STAT_FILT_BIT = 8;

  function automatic logic dpv_filter_on(input logic [1:0] mode);
    return mode == MODE_NATIVE_FILT;
  endfunction

endpackage

// file: rtl/dpv_ctrl_filter.sv
// Purpose: minimum pulse width filter for the control signals
// Assumes: runs on the pixel clock, reset already synchronised
// Notes: fixed latency of DEPTH+1 clocks whether on or off
`timescale 1ns/100ps
module dpv_ctrl_filter #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 3
) (
  input logic clock_in,
  input logic reset_n_in,
  input logic enable_in,
  input logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] level_out
);
  import dpv_pkg::*;

  logic [DEPTH-1:0] hist [WIDTH];
  logic [DEPTH-1:0] next_hist [WIDTH];
  logic [WIDTH-1:0] next_level;
  logic [WIDTH-1:0] settled;
  logic [WIDTH-1:0] newest;
  logic [WIDTH-1:0] oldest;

  always_comb begin
    for (int b = 0; b < WIDTH; b++) begin
      next_hist[b] = {hist[b][DEPTH-2:0], level_in[b]};
      settled[b] = (&hist[b]) | ~(|hist[b]);
      newest[b] = hist[b][0];
      oldest[b] = hist[b][DEPTH-1];
      if (!enable_in) begin
        next_level[b] = oldest[b];
      end else if (settled[b]) begin
        next_level[b] = newest[b];
      end else begin
        next_level[b] = level_out[b];
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int b = 0; b < WIDTH; b++) begin
        hist[b] <= '0;
      end
      level_out <= '0;
    end else begin
      hist <= next_hist;
      level_out <= next_level;
    end
  end

  AST_FILTER_HOLDS_SHORT: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    $past(enable_in) |->
      ((level_out ^ $past(level_out)) & ~$past(settled)) == '0)
    else $error("control level changed before settling");

  AST_FILTER_PASSES_WIDE: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    $past(enable_in) |->
      ((level_out ^ $past(newest)) & $past(settled)) == '0)
    else $error("settled control level not passed");

  AST_FILTER_OFF_FOLLOWS: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    !$past(enable_in) |-> level_out == $past(oldest))
    else $error("unfiltered control level not passed");

endmodule // dpv_ctrl_filter

// file: rtl/dpv_video_out.sv
// Purpose: parallel video output stage with straps and output-state control
// Assumes: pixel clock free-running; lock and pins asynchronous to clock_in
// Notes: power-down input also restarts the strap sequence
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
module dpv_video_out (
  input logic clock_in,
  input logic reset_n_in,
  input logic pixel_clock_in,
  input logic power_down_n_in,
  input logic output_state_select_in,
  input logic rx_locked_in,
  input dpv_pkg::dpv_pixel_t rx_pixel_in,
  input dpv_pkg::dpv_rgb_t colour_pin_in,
  output dpv_pkg::dpv_rgb_t colour_pin_out,
  output logic [23:0] colour_oe_out,
  output logic pixel_valid_out,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic ctrl_oe_out,
  output logic pixel_clock_gate_out,
  output logic clock_invert_out,
  output logic locked_out,
  input logic [dpv_pkg::ADDR_W-1:0] reg_addr_in,
  input logic [31:0] reg_wdata_in,
  input logic reg_write_in,
  input logic reg_read_in,
  output logic [31:0] reg_rdata_out
);
  import dpv_pkg::*;

  typedef enum logic [1:0] {ST_DOWN, ST_STRAP, ST_RUN} dpv_state_t;

  // system domain synchronisers
  logic pd_meta, pd_q;
  logic oss_meta, oss_q;
  logic lock_meta, lock_q;
  dpv_rgb_t colour_meta, colour_q;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pd_meta <= 1'b0;
      pd_q <= 1'b0;
      oss_meta <= 1'b0;
      oss_q <= 1'b0;
      lock_meta <= 1'b0;
      lock_q <= 1'b0;
      colour_meta <= '0;
      colour_q <= '0;
    end else begin
      pd_meta <= power_down_n_in;
      pd_q <= pd_meta;
      oss_meta <= output_state_select_in;
      oss_q <= oss_meta;
      lock_meta <= rx_locked_in;
      lock_q <= lock_meta;
      colour_meta <= colour_pin_in;
      colour_q <= colour_meta;
    end
  end

  // power-up sequence and strap capture
  dpv_state_t state, next_state;
  logic [STRAP_CNT_W-1:0] strap_cnt, next_strap_cnt;
  dpv_rgb_t strap_word, next_strap_word;
  logic [1:0] strap_mode;

  assign strap_mode = strap_word.blue[STRAP_MODE_LSB +: 2];

  always_comb begin
    next_state = state;
    next_strap_cnt = strap_cnt;
    next_strap_word = strap_word;
    if (!pd_q) begin
      next_state = ST_DOWN;
      next_strap_cnt = STRAP_CNT_LOAD;
    end else begin
      unique case (state)
        ST_DOWN: begin
          next_state = ST_STRAP;
          next_strap_cnt = STRAP_CNT_LOAD;
        end
        ST_STRAP: begin
          if (strap_cnt == '0) begin
            next_state = ST_RUN;
            next_strap_word = colour_q;
          end else begin
            next_strap_cnt = strap_cnt - 1'b1;
          end
        end
        ST_RUN: begin
          next_state = ST_RUN;
        end
      endcase
    end
  end

  // undriven strap pins read low through the pad pulldown
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_STRAP;
      strap_cnt <= STRAP_CNT_LOAD;
      strap_word <= '0;
    end else begin
      state <= next_state;
      strap_cnt <= next_strap_cnt;
      strap_word <= next_strap_word;
    end
  end

  // register file
  logic ctrl_ovr, next_ctrl_ovr;
  logic [1:0] ctrl_mode, next_ctrl_mode;
  logic ctrl_edge, next_ctrl_edge;
  logic [31:0] next_rdata;
  logic [1:0] eff_mode;

  // a software override keeps strap wiring errors recoverable
  assign eff_mode = ctrl_ovr ? ctrl_mode : strap_mode;

  always_comb begin
    next_ctrl_ovr = ctrl_ovr;
    next_ctrl_mode = ctrl_mode;
    next_ctrl_edge = ctrl_edge;
    next_rdata = '0;
    if (reg_write_in && reg_addr_in == ADDR_CTRL) begin
      next_ctrl_ovr = reg_wdata_in[CTRL_OVR_BIT];
      next_ctrl_mode = reg_wdata_in[CTRL_MODE_LSB +: 2];
      next_ctrl_edge = reg_wdata_in[CTRL_EDGE_BIT];
    end
    if (reg_read_in) begin
      unique case (reg_addr_in)
        ADDR_CTRL: begin
          next_rdata[CTRL_OVR_BIT] = ctrl_ovr;
          next_rdata[CTRL_MODE_LSB +: 2] = ctrl_mode;
          next_rdata[CTRL_EDGE_BIT] = ctrl_edge;
        end
        ADDR_STATUS: begin
          next_rdata[STAT_LOCK_BIT] = lock_q;
          next_rdata[STAT_PD_BIT] = pd_q;
          next_rdata[STAT_RUN_BIT] = state == ST_RUN;
          next_rdata[STAT_ACTIVE_BIT] = locked_out;
          next_rdata[STAT_STRAP_LSB +: 2] = strap_mode;
          next_rdata[STAT_MODE_LSB +: 2] = eff_mode;
          next_rdata[STAT_FILT_BIT] = dpv_filter_on(eff_mode);
        end
        ADDR_STRAP: begin
          next_rdata[23:0] = strap_word;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_ovr <= CTRL_OVR_RESET;
      ctrl_mode <= CTRL_MODE_RESET;
      ctrl_edge <= CTRL_EDGE_RESET;
      reg_rdata_out <= '0;
    end else begin
      ctrl_ovr <= next_ctrl_ovr;
      ctrl_mode <= next_ctrl_mode;
      ctrl_edge <= next_ctrl_edge;
      reg_rdata_out <= next_rdata;
    end
  end

  // pad control, computed from the next state so all pins move together
  logic video_active, next_video_active;
  logic filt_en, next_filt_en;
  logic next_ctrl_oe;
  logic [23:0] next_colour_oe;

  always_comb begin
    next_video_active = (next_state == ST_RUN) && lock_q;
    next_filt_en = dpv_filter_on(eff_mode);
    next_ctrl_oe = next_video_active | ~oss_q;
    if (next_state == ST_STRAP) begin
      next_colour_oe = '0;
    end else begin
      next_colour_oe = {24{next_video_active | ~oss_q}};
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      video_active <= 1'b0;
      filt_en <= 1'b0;
      ctrl_oe_out <= 1'b0;
      colour_oe_out <= '0;
      locked_out <= 1'b0;
      pixel_clock_gate_out <= 1'b0;
      clock_invert_out <= 1'b0;
    end else begin
      video_active <= next_video_active;
      filt_en <= next_filt_en;
      ctrl_oe_out <= next_ctrl_oe;
      colour_oe_out <= next_colour_oe;
      locked_out <= next_video_active;
      pixel_clock_gate_out <= next_video_active;
      clock_invert_out <= ~ctrl_edge;
    end
  end

  // pixel domain: reset release and level crossings
  logic px_rst_meta, px_rst_n;
  logic active_meta, active_px;
  logic filt_meta, filt_px;

  always_ff @(posedge pixel_clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      px_rst_meta <= 1'b0;
      px_rst_n <= 1'b0;
    end else begin
      px_rst_meta <= 1'b1;
      px_rst_n <= px_rst_meta;
    end
  end

  // quasi-static levels, so a plain two-stage crossing suffices
  always_ff @(posedge pixel_clock_in or negedge px_rst_n) begin
    if (!px_rst_n) begin
      active_meta <= 1'b0;
      active_px <= 1'b0;
      filt_meta <= 1'b0;
      filt_px <= 1'b0;
    end else begin
      active_meta <= video_active;
      active_px <= active_meta;
      filt_meta <= filt_en;
      filt_px <= filt_meta;
    end
  end

  // data delayed to line up with the filtered control pair
  dpv_pixel_t pipe [PIPE_DEPTH];
  dpv_pixel_t next_pipe [PIPE_DEPTH];
  logic [1:0] ctrl_filtered;
  dpv_rgb_t next_colour;
  logic next_pixel_valid, next_line_sync, next_frame_sync;

  dpv_ctrl_filter #(
    .WIDTH(2),
    .DEPTH(FILTER_MIN_CLOCKS)
  ) u_ctrl_filter (
    .clock_in(pixel_clock_in),
    .reset_n_in(px_rst_n),
    .enable_in(filt_px),
    .level_in({rx_pixel_in.line_sync, rx_pixel_in.pixel_valid}),
    .level_out(ctrl_filtered)
  );

  always_comb begin
    next_pipe[0] = rx_pixel_in;
    for (int i = 1; i < PIPE_DEPTH; i++) begin
      next_pipe[i] = pipe[i-1];
    end
    // inactive outputs sit low; the pads decide drive or release
    next_colour = active_px ? pipe[PIPE_DEPTH-1].rgb : '0;
    next_pixel_valid = active_px & ctrl_filtered[0];
    next_line_sync = active_px & ctrl_filtered[1];
    next_frame_sync = active_px & pipe[PIPE_DEPTH-1].frame_sync;
  end

  always_ff @(posedge pixel_clock_in or negedge px_rst_n) begin
    if (!px_rst_n) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe[i] <= '0;
      end
      colour_pin_out <= '0;
      pixel_valid_out <= 1'b0;
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
    end else begin
      pipe <= next_pipe;
      colour_pin_out <= next_colour;
      pixel_valid_out <= next_pixel_valid;
      line_sync_out <= next_line_sync;
      frame_sync_out <= next_frame_sync;
    end
  end

  sequence s_wake;
    $rose(pd_q) ##1 pd_q [*8];
  endsequence

  AST_OE_IN_POWER_DOWN: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    !pd_q |=> colour_oe_out == {24{!$past(oss_q)}})
    else $error("colour pads ignore output-state select");

  AST_CTRL_MUTED: assert property (
    @(posedge pixel_clock_in) disable iff (!px_rst_n)
    !active_px |=> !pixel_valid_out && !line_sync_out &&
      !frame_sync_out && colour_pin_out == '0)
    else $error("video outputs not muted while inactive");

  AST_STRAP_PINS_INPUT: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    s_wake |-> colour_oe_out == '0 && !locked_out)
    else $error("colour pads driven during strap window");

  AST_STRAP_CAPTURE: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    ($past(state) == ST_STRAP && state == ST_RUN) |->
      strap_word == $past(colour_q))
    else $error("strap word not taken at end of window");

  AST_EDGE_SELECT: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    (reg_write_in && reg_addr_in == ADDR_CTRL) |->
      ##2 clock_invert_out == !$past(reg_wdata_in[CTRL_EDGE_BIT], 2))
    else $error("clock edge select not applied");

  AST_LOCK_STATUS: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    locked_out |-> $past(lock_q) && $past(pd_q) &&
      pixel_clock_gate_out && ctrl_oe_out)
    else $error("locked shown without lock or active outputs");

endmodule // dpv_video_out

// file: dv/dpv_panel_model.sv
// Purpose: panel side of the video outputs, with strap resistors on pads
// Assumes: panel samples the outputs on the rising pixel clock
// Notes: keeps running counts of control-signal activity
`timescale 1ns/100ps
module dpv_panel_model (
  input logic pix_clk_in,
  input logic [23:0] strap_in,
  input dpv_pkg::dpv_rgb_t pin_in,
  input logic [23:0] oe_in,
  input logic pv_in,
  input logic ls_in,
  output dpv_pkg::dpv_rgb_t pad_out,
  output int pv_hi_out,
  output int pv_rise_out,
  output int ls_hi_out
);
  import dpv_pkg::*;
  logic pv_q;
  // released pad settles to its resistor; unfitted means pulled low
  always_comb pad_out = (oe_in & pin_in) | (~oe_in & strap_in);
  initial begin
    pv_q = 1'b0;
    pv_hi_out = 0;
    pv_rise_out = 0;
    ls_hi_out = 0;
  end
  always @(posedge pix_clk_in) begin
    pv_hi_out <= pv_hi_out + int'(pv_in);
    ls_hi_out <= ls_hi_out + int'(ls_in);
    pv_rise_out <= pv_rise_out + int'(pv_in & ~pv_q);
    pv_q <= pv_in;
  end
endmodule // dpv_panel_model

// file: dv/deser_parallel_video_output_test.sv
// Purpose: self-checking bench for the parallel video output stage
// Assumes: pixel clock free-running at 64 ns, unrelated to clock_in
// Notes: output data appears 5 pixel edges after it is driven
`timescale 1ns/100ps
module deser_parallel_video_output_test;
  import dpv_pkg::*;
  logic clk = 0, pix_clk = 0, rst_n = 0, pd_n = 0, oss = 0, lock = 1;
  logic rd = 0, wr = 0, vid_on = 0, pv, ls, fs, coe, gate, inv, lkd;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [23:0] oe, strap = 24'ha53c41;
  logic [24:0] hist[16];
  dpv_pixel_t rx = '0;
  dpv_rgb_t pin_in, pin_out;
  int error_cnt = 0, num_checks = 0, seed = 32'h7c95, pc = 0;
  int pvh, pvr, lsh, h0, r0, l0, m, ea, eb;
  int pw[2] = '{1, 1};
  int ta[4] = '{1, 2, 1, 2};
  int tb[4] = '{1, 3, 2, 1};

  initial forever #12.5 clk = ~clk;
  initial begin
    #7;
    forever #32 pix_clk = ~pix_clk;
  end

  dpv_video_out uut (.clock_in(clk), .reset_n_in(rst_n),
    .pixel_clock_in(pix_clk), .power_down_n_in(pd_n),
    .output_state_select_in(oss), .rx_locked_in(lock), .rx_pixel_in(rx),
    .colour_pin_in(pin_in), .colour_pin_out(pin_out), .colour_oe_out(oe),
    .pixel_valid_out(pv), .line_sync_out(ls), .frame_sync_out(fs),
    .ctrl_oe_out(coe), .pixel_clock_gate_out(gate),
    .clock_invert_out(inv), .locked_out(lkd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata));

  dpv_panel_model panel (.pix_clk_in(pix_clk), .strap_in(strap),
    .pin_in(pin_out), .oe_in(oe), .pv_in(pv), .ls_in(ls), .pad_out(pin_in),
    .pv_hi_out(pvh), .pv_rise_out(pvr), .ls_hi_out(lsh));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] msk,
                        input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & msk, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_lk(input logic e);
    int k;
    for (k = 0; k < 300 && lkd !== e; k++) @(posedge clk);
    #1;
    if (lkd !== e) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic outs(input logic [23:0] eo, input logic ec);
    chk(32'(oe), 32'(eo));
    chk(32'(coe), 32'(ec));
  endtask

  function automatic logic [31:0] stat(input logic [1:0] s, e);
    return {23'h0, e == 2'h1, e, s, 4'h0};
  endfunction

  function automatic int hi_exp(input logic f, input int w);
    return (f && w < 3) ? 0 : w;
  endfunction

  // random pixel stream; control pulses 140 clocks apart
  always @(posedge pix_clk) begin
    logic [23:0] v;
    logic c;
    logic f;
    v = 24'($random(seed));
    f = (pc % 512) >= 256;
    hist[pc % 16] = {f, v};
    c = (pc % 140 >= 20) && (pc % 140 < 20 + pw[(pc / 140) % 2]);
    rx <= '{rgb: v, frame_sync: f, line_sync: c, pixel_valid: c};
    pc++;
  end

  // outputs looked at mid-cycle, well clear of the launching edge
  always @(negedge pix_clk) begin
    if (vid_on && pc > 6)
      chk(32'({fs, pin_out}), 32'(hist[(pc - 6) % 16]));
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
    outs(24'hffffff, 1'b1);
    chk(32'({pin_out, pv, ls, fs}), 32'h0);
    reg_rd(ADDR_CTRL, 32'hf, 32'h8);
    chk(32'(inv), 32'h0);
    reg_rd(4'hc, 32'hffffffff, 32'h0);
    @(posedge clk) oss <= 1'b1;
    cyc(4);
    outs(24'h0, 1'b0);
    @(posedge clk) oss <= 1'b0;
    pd_n <= 1'b1;
    cyc(6);
    outs(24'h0, 1'b1);
    wait_lk(1'b1);
    outs(24'hffffff, 1'b1);
    chk(32'(gate), 32'h1);
    reg_rd(ADDR_STRAP, 32'hffffff, 32'(strap));
    reg_rd(ADDR_STATUS, 32'h1f0, stat(2'h1, 2'h1));
    repeat (20) @(negedge pix_clk);
    vid_on = 1'b1;
    for (m = 0; m < 4; m++) begin
      reg_wr(ADDR_CTRL, {29'h1, 2'(m), 1'b1});
      reg_rd(ADDR_STATUS, 32'h1f0, stat(2'h1, 2'(m)));
      for (ea = 0; ea < 300 && pc % 280 != 0; ea++) @(negedge pix_clk);
      chk(32'(pc % 280), 32'h0);
      pw[0] = ta[m];
      pw[1] = tb[m];
      repeat (280) @(negedge pix_clk);
      h0 = pvh;
      r0 = pvr;
      l0 = lsh;
      repeat (280) @(negedge pix_clk);
      ea = hi_exp(m == 1, ta[m]);
      eb = hi_exp(m == 1, tb[m]);
      chk(32'(pvh - h0), 32'(ea + eb));
      chk(32'(lsh - l0), 32'(ea + eb));
      chk(32'(pvr - r0), 32'(int'(ea > 0) + int'(eb > 0)));
    end
    reg_wr(ADDR_CTRL, 32'h0);
    cyc(2);
    chk(32'(inv), 32'h1);
    reg_wr(ADDR_CTRL, 32'h8);
    cyc(2);
    chk(32'(inv), 32'h0);
    vid_on = 1'b0;
    @(posedge clk) lock <= 1'b0;
    wait_lk(1'b0);
    cyc(4);
    outs(24'hffffff, 1'b1);
    chk(32'(gate), 32'h0);
    repeat (10) @(negedge pix_clk);
    chk(32'({pin_out, pv, ls, fs}), 32'h0);
    strap = 24'h123480;
    @(posedge clk) lock <= 1'b1;
    pd_n <= 1'b0;
    oss <= 1'b1;
    cyc(4);
    outs(24'h0, 1'b0);
    chk(32'(lkd), 32'h0);
    @(posedge clk) pd_n <= 1'b1;
    cyc(6);
    outs(24'h0, 1'b0);
    wait_lk(1'b1);
    outs(24'hffffff, 1'b1);
    reg_rd(ADDR_STRAP, 32'hffffff, 32'(strap));
    reg_rd(ADDR_STATUS, 32'h1f0, stat(2'h2, 2'h2));
    repeat (20) @(negedge pix_clk);
    vid_on = 1'b1;
    repeat (40) @(negedge pix_clk);
    close_out();
  end
endmodule // deser_parallel_video_output_test
